// ==== src/otfr_defs.vh ====
// Constants of the over-temperature fault response block.
// Assumes includers use these names only; no logic lives here.
`ifndef OTFR_DEFS_VH
`define OTFR_DEFS_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define OTFR_CMD_FAULT_LIMIT 8'h4F
`define OTFR_CMD_ACTION_CFG 8'h50
`define OTFR_CMD_WARN_LIMIT 8'h51
`define OTFR_CMD_CLEAR_FAULTS 8'h03
`define OTFR_CMD_STATUS_WORD 8'h79
`define OTFR_CMD_STATUS_TEMP 8'h7D

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define OTFR_ACTION_RST 8'hBF
`define OTFR_WARN_RST 16'hEB70
`define OTFR_FAULT_RST 16'hEBE8

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define OTFR_RESP_HI 7
`define OTFR_RESP_LO 6
`define OTFR_RETRY_HI 5
`define OTFR_RETRY_LO 3
`define OTFR_DELAY_HI 2
`define OTFR_DELAY_LO 0
`define OTFR_RESP_RETRY 2'h2
`define OTFR_RESP_HOLD 2'h3
`define OTFR_RETRY_NONE 3'h0
`define OTFR_RETRY_CONT 3'h7
`define OTFR_STT_OT_FAULT 7
`define OTFR_STT_OT_WARN 6
`define OTFR_STW_TEMP 2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OTFR_CLK_KHZ 40000
`define OTFR_RETRY_UNIT_MS 35
`define OTFR_UNIT_CYCLES (`OTFR_RETRY_UNIT_MS * `OTFR_CLK_KHZ)

`endif

// ==== src/otfr_linear11_cmp.v ====
// Compares two Linear-11 values (signed 5-bit exponent, signed 11-bit
// mantissa). Assumes both inputs are steady during the cycle.
`timescale 1ns/1ps

module otfr_linear11_cmp (
  // Operands
  input wire [15:0] lhs,
  input wire [15:0] rhs,
  // Results
  output wire lhsAbove,
  output wire lhsBelow
);

  // ----------------------------------------------------------
  // Scale to fixed point with 16 fraction bits
  // ----------------------------------------------------------
  wire [5:0] shL;
  wire [5:0] shR;
  wire signed [47:0] valL;
  wire signed [47:0] valR;

  assign shL = {lhs[15], lhs[15:11]} + 6'h10;
  assign shR = {rhs[15], rhs[15:11]} + 6'h10;
  assign valL = $signed({{37{lhs[10]}}, lhs[10:0]}) <<< shL[4:0];
  assign valR = $signed({{37{rhs[10]}}, rhs[10:0]}) <<< shR[4:0];
  assign lhsAbove = valL > valR;
  assign lhsBelow = valL < valR;

endmodule // otfr_linear11_cmp

// ==== src/otfr_retry_timer.v ====
// Retry interval timer: counts 35 ms units from a restart pulse.
// Assumes delaySel is steady while a count runs.
`timescale 1ns/1ps

module otfr_retry_timer #(
  parameter UNIT_CYCLES = 1400000
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire restart,
  input wire [2:0] delaySel,
  // Status
  output wire elapsed
);

  // ----------------------------------------------------------
  // Unit divider and unit counter
  // ----------------------------------------------------------
  reg [31:0] divCnt_q;
  reg [3:0] unitCnt_q;
  reg done_q;
  wire unitTick;
  wire [3:0] target;

  assign unitTick = (divCnt_q == UNIT_CYCLES - 1);
  assign target = {1'b0, delaySel} + 4'h1;
  assign elapsed = done_q;

  always @(posedge clk) begin
    if (sys_rst || restart) begin
      divCnt_q <= 32'h0;
      unitCnt_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (unitTick) begin
        divCnt_q <= 32'h0;
        unitCnt_q <= unitCnt_q + 4'h1;
        // At or past target, so a shorter delay written mid-count cannot
        // push the restart out by a full wrap of the unit counter
        if (unitCnt_q + 4'h1 >= target) begin
          done_q <= 1'b1;
        end
      end else begin
        divCnt_q <= divCnt_q + 32'h1;
      end
    end
  end

endmodule // otfr_retry_timer

// ==== src/otfr_top.v ====
// Over-temperature fault response for each output page: settings,
// status bits, alert line and the disable/retry sequence.
// Assumes commands arrive already decoded from the management bus,
// one-cycle cmdValid, and temperatures in Linear-11 per page.
`timescale 1ns/1ps
`include "otfr_defs.vh"

module otfr_top #(
  parameter PAGES = 2,
  parameter PAGE_W = 1,
  parameter UNIT_CYCLES = `OTFR_UNIT_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Decoded command port
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire [15:0] cmdWrData,
  input wire [PAGE_W-1:0] pageSel,
  input wire writeProtect,
  output reg [15:0] cmdRdData_q,
  output reg cmdRdValid_q,
  output reg cmdErr_q,
  // Per-page operating inputs
  input wire [16*PAGES-1:0] tempReading,
  input wire [PAGES-1:0] enableOn,
  input wire [PAGES-1:0] otherFaultOff,
  // Per-page outputs and status
  output wire [PAGES-1:0] outputEnable,
  output wire [PAGES-1:0] statusOtFault,
  output wire [PAGES-1:0] statusOtWarn,
  output wire [PAGES-1:0] statusWordTemp,
  // Open-drain alert
  input wire hostAlertLineNIn,
  output wire hostAlertLineNOut,
  output wire hostAlertLineNOeN
);

  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_HOLD = 5'h02;
  localparam [4:0] ST_COOL = 5'h04;
  localparam [4:0] ST_LATCH = 5'h08;
  localparam [4:0] ST_OFF = 5'h10;

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  wire pageOk;
  wire wrOk;
  wire clearCmd;
  wire [8*PAGES-1:0] actionFlat;
  wire [16*PAGES-1:0] warnFlat;
  wire [16*PAGES-1:0] faultLimFlat;

  assign pageOk = ({1'b0, pageSel} < PAGES);
  // Protected registers ignore writes while protection is on
  assign wrOk = cmdValid && cmdWrite && pageOk && !writeProtect;
  assign clearCmd = cmdValid && cmdWrite && pageOk &&
                    (cmdCode == `OTFR_CMD_CLEAR_FAULTS);

  // ----------------------------------------------------------
  // Per-page logic
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PAGES; g = g + 1) begin : gPage
      reg [7:0] action_q;
      reg [15:0] warnLim_q;
      reg [15:0] faultLim_q;
      reg [4:0] state_q;
      reg [4:0] state_d;
      reg outEn_q;
      reg outEn_d;
      reg restart_d;
      reg otFault_q;
      reg otWarn_q;
      wire sel;
      wire [15:0] temp;
      wire faultNow;
      wire aboveWarn;
      wire belowWarn;
      wire retryDone;
      wire [1:0] resp;
      wire [2:0] retry;
      wire offReq;
      wire clearMe;

      assign sel = (pageSel == g);
      assign clearMe = clearCmd && sel;
      assign temp = tempReading[16*g +: 16];
      assign resp = action_q[`OTFR_RESP_HI:`OTFR_RESP_LO];
      assign retry = action_q[`OTFR_RETRY_HI:`OTFR_RETRY_LO];
      assign offReq = !enableOn[g] || otherFaultOff[g];

      // Settings, one copy per page
      always @(posedge clk) begin
        if (sys_rst) begin
          action_q <= `OTFR_ACTION_RST;
          warnLim_q <= `OTFR_WARN_RST;
          faultLim_q <= `OTFR_FAULT_RST;
        end else if (wrOk && sel) begin
          if (cmdCode == `OTFR_CMD_ACTION_CFG) begin
            action_q <= cmdWrData[7:0];
          end
          if (cmdCode == `OTFR_CMD_WARN_LIMIT) begin
            warnLim_q <= cmdWrData;
          end
          if (cmdCode == `OTFR_CMD_FAULT_LIMIT) begin
            faultLim_q <= cmdWrData;
          end
        end
      end

      otfr_linear11_cmp uFaultCmp (
        .lhs(temp),
        .rhs(faultLim_q),
        .lhsAbove(faultNow),
        .lhsBelow()
      );

      otfr_linear11_cmp uWarnCmp (
        .lhs(temp),
        .rhs(warnLim_q),
        .lhsAbove(aboveWarn),
        .lhsBelow(belowWarn)
      );

      otfr_retry_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
      ) uTimer (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart_d),
        .delaySel(action_q[`OTFR_DELAY_HI:`OTFR_DELAY_LO]),
        .elapsed(retryDone)
      );

      // Sticky status: a new event wins over a clear
      always @(posedge clk) begin
        if (sys_rst) begin
          otFault_q <= 1'b0;
          otWarn_q <= 1'b0;
        end else begin
          if (faultNow) begin
            otFault_q <= 1'b1;
          end else if (clearMe) begin
            otFault_q <= 1'b0;
          end
          if (aboveWarn) begin
            otWarn_q <= 1'b1;
          end else if (clearMe) begin
            otWarn_q <= 1'b0;
          end
        end
      end

      // Response sequence
      always @* begin
        state_d = state_q;
        outEn_d = outEn_q;
        restart_d = 1'b0;
        case (state_q)
          ST_RUN: begin
            if (offReq) begin
              state_d = ST_OFF;
              outEn_d = 1'b0;
            end else if (faultNow && resp == `OTFR_RESP_HOLD) begin
              state_d = ST_HOLD;
              outEn_d = 1'b0;
            end else if (faultNow && resp == `OTFR_RESP_RETRY) begin
              outEn_d = 1'b0;
              if (retry == `OTFR_RETRY_CONT) begin
                state_d = ST_COOL;
              end else begin
                state_d = ST_LATCH;
              end
            end
          end
          ST_HOLD: begin
            if (offReq) begin
              state_d = ST_OFF;
            end else if (belowWarn) begin
              state_d = ST_RUN;
              outEn_d = 1'b1;
              restart_d = 1'b1;
            end
          end
          ST_COOL: begin
            if (offReq) begin
              state_d = ST_OFF;
            end else if (belowWarn && retryDone) begin
              state_d = ST_RUN;
              outEn_d = 1'b1;
              restart_d = 1'b1;
            end
          end
          ST_LATCH: begin
            if (offReq) begin
              state_d = ST_OFF;
            end else if (clearMe) begin
              state_d = ST_RUN;
              outEn_d = 1'b1;
              restart_d = 1'b1;
            end
          end
          ST_OFF: begin
            if (!offReq) begin
              state_d = ST_RUN;
              outEn_d = 1'b1;
              restart_d = 1'b1;
            end
          end
          default: begin
            state_d = ST_OFF;
            outEn_d = 1'b0;
          end
        endcase
      end

      always @(posedge clk) begin
        if (sys_rst) begin
          state_q <= ST_OFF;
          outEn_q <= 1'b0;
        end else begin
          state_q <= state_d;
          outEn_q <= outEn_d;
        end
      end

      assign outputEnable[g] = outEn_q;
      assign statusOtFault[g] = otFault_q;
      assign statusOtWarn[g] = otWarn_q;
      assign statusWordTemp[g] = otFault_q || otWarn_q;
      assign actionFlat[8*g +: 8] = action_q;
      assign warnFlat[16*g +: 16] = warnLim_q;
      assign faultLimFlat[16*g +: 16] = faultLim_q;
    end
  endgenerate

  // ----------------------------------------------------------
  // Alert line: held low while any status bit is set
  // ----------------------------------------------------------
  wire alertAny;

  assign alertAny = |{statusOtFault, statusOtWarn};
  assign hostAlertLineNOut = 1'b0;
  assign hostAlertLineNOeN = !alertAny;

  // ----------------------------------------------------------
  // Read path and command answer
  // ----------------------------------------------------------
  reg [15:0] rdData_d;
  reg rdHit_d;
  reg wrHit_d;

  always @* begin
    rdData_d = 16'h0000;
    rdHit_d = 1'b0;
    wrHit_d = 1'b0;
    if (pageOk) begin
      case (cmdCode)
        `OTFR_CMD_ACTION_CFG: begin
          rdData_d = {8'h00, actionFlat[8*pageSel +: 8]};
          rdHit_d = 1'b1;
          wrHit_d = !writeProtect;
        end
        `OTFR_CMD_WARN_LIMIT: begin
          rdData_d = warnFlat[16*pageSel +: 16];
          rdHit_d = 1'b1;
          wrHit_d = !writeProtect;
        end
        `OTFR_CMD_FAULT_LIMIT: begin
          rdData_d = faultLimFlat[16*pageSel +: 16];
          rdHit_d = 1'b1;
          wrHit_d = !writeProtect;
        end
        `OTFR_CMD_STATUS_TEMP: begin
          rdData_d[`OTFR_STT_OT_FAULT] = statusOtFault[pageSel];
          rdData_d[`OTFR_STT_OT_WARN] = statusOtWarn[pageSel];
          rdHit_d = 1'b1;
        end
        `OTFR_CMD_STATUS_WORD: begin
          rdData_d[`OTFR_STW_TEMP] = statusWordTemp[pageSel];
          rdHit_d = 1'b1;
        end
        `OTFR_CMD_CLEAR_FAULTS: begin
          wrHit_d = 1'b1;
        end
        default: begin
          rdHit_d = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      cmdRdData_q <= 16'h0000;
      cmdRdValid_q <= 1'b0;
      cmdErr_q <= 1'b0;
    end else begin
      cmdRdValid_q <= cmdValid && !cmdWrite;
      cmdErr_q <= cmdValid && (cmdWrite ? !wrHit_d : !rdHit_d);
      if (cmdValid && !cmdWrite) begin
        cmdRdData_q <= rdData_d;
      end
    end
  end

endmodule // otfr_top

// ==== test/otfr_top_properties.sv ====
// Port checker for otfr_top, bound to every instance.
// Assumes one clk domain with synchronous active-high sys_rst.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module otfr_top_properties #(
  parameter PAGES = 2,
  parameter PAGE_W = 1
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Command port
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire writeProtect,
  input wire [15:0] cmdRdData_q,
  input wire cmdRdValid_q,
  input wire cmdErr_q,
  // Page controls and status
  input wire [PAGES-1:0] enableOn,
  input wire [PAGES-1:0] otherFaultOff,
  input wire [PAGES-1:0] outputEnable,
  input wire [PAGES-1:0] statusOtFault,
  input wire [PAGES-1:0] statusOtWarn,
  input wire [PAGES-1:0] statusWordTemp,
  input wire hostAlertLineNOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire anyStatus = |{statusOtFault, statusOtWarn};
  wire clrCmd = cmdValid && cmdWrite && cmdCode == 8'h03;

  property p_alert_low; anyStatus |-> !hostAlertLineNOeN; endproperty
  property p_alert_idle; !anyStatus |-> hostAlertLineNOeN; endproperty
  property p_fault_off; $rose(statusOtFault[0]) |-> !outputEnable[0];
  endproperty
  property p_fault_sticky; statusOtFault[0] && !clrCmd |=> statusOtFault[0];
  endproperty
  property p_warn_word;
    $rose(statusOtWarn[0]) |-> statusWordTemp[0] && !hostAlertLineNOeN;
  endproperty
  property p_cmd_off; !enableOn[0] || otherFaultOff[0] |=> !outputEnable[0];
  endproperty
  property p_wp_err;
    cmdValid && cmdWrite && writeProtect && cmdCode == 8'h50
      |=> cmdErr_q && !cmdRdValid_q;
  endproperty
  property p_cfg_byte;
    cmdValid && !cmdWrite && cmdCode == 8'h50
      |=> cmdRdValid_q && cmdRdData_q[15:8] == 8'h00;
  endproperty
  property p_rd_cause; cmdRdValid_q |-> $past(cmdValid) && !$past(cmdWrite);
  endproperty

  a_alert_low: assert property (p_alert_low)
    else $error("alert released while status set");
  a_alert_idle: assert property (p_alert_idle)
    else $error("alert pulled with no status");
  a_fault_off: assert property (p_fault_off)
    else $error("output on when fault bit rose");
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault bit dropped without clear");
  a_warn_word: assert property (p_warn_word)
    else $error("warning not reflected in word or alert");
  a_cmd_off: assert property (p_cmd_off)
    else $error("output on while commanded off");
  a_wp_err: assert property (p_wp_err)
    else $error("protected write not refused");
  a_cfg_byte: assert property (p_cfg_byte)
    else $error("setting read not a single byte");
  a_rd_cause: assert property (p_rd_cause)
    else $error("read valid without a read");

  c_fault: cover property ($rose(statusOtFault[0]));
  c_retry: cover property ($rose(outputEnable[0]) && statusOtFault[0]);
  c_err: cover property (cmdErr_q);
endmodule // otfr_top_properties

bind otfr_top otfr_top_properties #(.PAGES(PAGES), .PAGE_W(PAGE_W)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
  .cmdCode(cmdCode), .writeProtect(writeProtect),
  .cmdRdData_q(cmdRdData_q), .cmdRdValid_q(cmdRdValid_q),
  .cmdErr_q(cmdErr_q), .enableOn(enableOn), .otherFaultOff(otherFaultOff),
  .outputEnable(outputEnable), .statusOtFault(statusOtFault),
  .statusOtWarn(statusOtWarn), .statusWordTemp(statusWordTemp),
  .hostAlertLineNOeN(hostAlertLineNOeN));

// ==== test/otfr_host_model.sv ====
// Management host model: issues decoded commands one at a time.
// Assumes the device answers one cycle after the strobe edge.
`timescale 1ns/1ps

module otfr_host_model #(
  parameter PAGE_W = 1
) (
  // Clock
  input wire clk,
  // Command port toward the device
  output reg cmdValid,
  output reg cmdWrite,
  output reg [7:0] cmdCode,
  output reg [15:0] cmdWrData,
  output reg [PAGE_W-1:0] pageSel,
  output reg writeProtect,
  // Answers
  input wire [15:0] cmdRdData_q,
  input wire cmdRdValid_q,
  input wire cmdErr_q
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'hFF;
    cmdWrData = 16'hFFFF;
    pageSel = {PAGE_W{1'b0}};
    writeProtect = 1'b0;
  end

  // ----------------------------------------------------------
  // One transfer; released fields show the inverse afterwards
  // ----------------------------------------------------------
  task xfer(input wr, input [7:0] code, input [15:0] data,
            input [PAGE_W-1:0] page, input wp,
            output [15:0] rd, output ok, output err);
    begin
      @(posedge clk);
      #1;
      pageSel = page;
      writeProtect = wp;
      cmdWrite = wr;
      cmdCode = code;
      cmdWrData = data;
      cmdValid = 1'b1;
      @(posedge clk);
      #1;
      cmdValid = 1'b0;
      cmdCode = ~code;
      cmdWrData = ~data;
      rd = cmdRdData_q;
      ok = cmdRdValid_q;
      err = cmdErr_q;
    end
  endtask
endmodule // otfr_host_model

// ==== test/otfr_top_tb.sv ====
// Self-checking bench for otfr_top with a host model on the command port.
// Assumes UNIT_CYCLES shortened to 10 and temperatures with exponent -3.
`timescale 1ns/1ps

module otfr_top_tb;
  localparam UNIT = 10;
  reg clk, sysRst;
  reg [31:0] tempReading;
  reg [1:0] enableOn, otherFaultOff;
  wire cmdValid, cmdWrite, writeProtect, rdValid, err0, alertOut, alertOeN;
  wire [7:0] cmdCode;
  wire [15:0] cmdWrData, rdData;
  wire [0:0] pageSel;
  wire [1:0] outEn, stFault, stWarn, stWord;
  wire alertWire = alertOeN ? 1'b1 : alertOut;
  integer mismatches = 0, nTests = 0, cycles = 0, i, d, n, k, lim, t;
  reg [15:0] rd;
  reg ok, err;

  otfr_top #(.UNIT_CYCLES(UNIT)) dut_u (.clk(clk), .sys_rst(sysRst),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWrData(cmdWrData), .pageSel(pageSel), .writeProtect(writeProtect),
    .cmdRdData_q(rdData), .cmdRdValid_q(rdValid), .cmdErr_q(err0),
    .tempReading(tempReading), .enableOn(enableOn),
    .otherFaultOff(otherFaultOff), .outputEnable(outEn),
    .statusOtFault(stFault), .statusOtWarn(stWarn), .statusWordTemp(stWord),
    .hostAlertLineNIn(alertWire), .hostAlertLineNOut(alertOut),
    .hostAlertLineNOeN(alertOeN));
  otfr_host_model host_u (.clk(clk), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
    .pageSel(pageSel), .writeProtect(writeProtect), .cmdRdData_q(rdData),
    .cmdRdValid_q(rdValid), .cmdErr_q(err0));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function [15:0] degL11(input [7:0] deg);
    degL11 = {5'h1D, deg, 3'h0};
  endfunction
  task chk(input [16:0] got, input [16:0] exp);
    begin
      nTests = nTests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] code, input [15:0] data, input pg);
    host_u.xfer(1'b1, code, data, pg, 1'b0, rd, ok, err);
  endtask
  task rdChk(input [7:0] code, input pg, input [15:0] exp);
    begin
      host_u.xfer(1'b0, code, 16'h0000, pg, 1'b0, rd, ok, err);
      chk({ok, rd}, {1'b1, exp});
    end
  endtask
  task setT(input pg, input [7:0] deg);
    tempReading[16*pg +: 16] = degL11(deg);
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task waitOe(input pg, input v, input integer lmt, output integer c);
    begin
      c = 0;
      while (outEn[pg] !== v && c < lmt) begin
        cyc(1);
        c = c + 1;
      end
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && nTests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles >= 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    n = $urandom(53994);
    sysRst = 1'b1;
    tempReading = {degL11(8'd40), degL11(8'd40)};
    enableOn = 2'b11;
    otherFaultOff = 2'b00;
    repeat (20) @(posedge clk);
    #1 sysRst = 1'b0;
    rdChk(8'h50, 1'b0, 16'h00BF);
    rdChk(8'h51, 1'b1, 16'hEB70);
    rdChk(8'h4F, 1'b0, 16'hEBE8);
    d = $urandom % 64;
    wr(8'h50, {10'h003, d[5:0]}, 1'b1);
    rdChk(8'h50, 1'b1, {10'h003, d[5:0]});
    rdChk(8'h50, 1'b0, 16'h00BF);
    host_u.xfer(1'b1, 8'h50, 16'h0080, 1'b0, 1'b1, rd, ok, err);
    chk(err, 1);
    rdChk(8'h50, 1'b0, 16'h00BF);
    host_u.xfer(1'b0, 8'hEE, 16'h0000, 1'b0, 1'b0, rd, ok, err);
    chk(err, 1);
    // Warning only
    setT(0, 8'd115);
    cyc(3);
    chk({stWarn[0], stWord[0], alertOeN, stFault[0], outEn[0]}, 5'h19);
    chk(alertWire, 0);
    rdChk(8'h7D, 1'b0, 16'h0040);
    rdChk(8'h79, 1'b0, 16'h0004);
    setT(0, 8'd40);
    wr(8'h03, 16'h0000, 1'b0);
    cyc(2);
    chk({stWarn[0], alertOeN, alertWire}, 3'b011);
    // Hold while hot, resume below warning
    wr(8'h50, 16'h00C0, 1'b0);
    setT(0, 8'd126);
    cyc(3);
    chk({outEn[0], stFault[0], alertOeN}, 3'b010);
    setT(0, 8'd115);
    cyc(20);
    chk(outEn[0], 0);
    setT(0, 8'd100);
    waitOe(0, 1'b1, 4, n);
    chk({outEn[0], stFault[0]}, 2'b11);
    wr(8'h03, 16'h0000, 1'b0);
    cyc(2);
    chk(stFault[0], 0);
    // Latched off for one random retry code from 000 to 110
    wr(8'h50, {10'h002, 3'($urandom % 7), 3'h0}, 1'b0);
    setT(0, 8'd126);
    cyc(3);
    setT(0, 8'd100);
    cyc(100);
    chk(outEn[0], 0);
    wr(8'h03, 16'h0000, 1'b0);
    waitOe(0, 1'b1, 6, n);
    chk(outEn[0], 1);
    // Continuous retry spacing for every delay code
    for (d = 0; d < 8; d = d + 1) begin
      wr(8'h50, {10'h002, 3'h7, d[2:0]}, 1'b0);
      setT(0, 8'd126);
      cyc(90);
      chk(outEn[0], 0);
      setT(0, 8'd100);
      waitOe(0, 1'b1, 4, n);
      setT(0, 8'd126);
      waitOe(0, 1'b0, 6, n);
      setT(0, 8'd100);
      waitOe(0, 1'b1, 200, k);
      chk(n + k >= (d + 1) * UNIT && n + k <= (d + 1) * UNIT + 2, 1);
    end
    setT(0, 8'd126);
    cyc(3);
    otherFaultOff[0] = 1'b1;
    setT(0, 8'd100);
    cyc(100);
    chk(outEn[0], 0);
    otherFaultOff[0] = 1'b0;
    waitOe(0, 1'b1, 100, n);
    enableOn[0] = 1'b0;
    cyc(3);
    chk(outEn[0], 0);
    enableOn[0] = 1'b1;
    // Random warning thresholds on the second page
    for (i = 0; i < 6; i = i + 1) begin
      lim = 20 + $urandom % 100;
      t = 20 + $urandom % 100;
      wr(8'h51, degL11(lim[7:0]), 1'b1);
      rdChk(8'h51, 1'b1, degL11(lim[7:0]));
      setT(1, t[7:0]);
      cyc(3);
      chk(stWarn[1], t > lim);
      setT(1, 8'd10);
      wr(8'h03, 16'h0000, 1'b1);
    end
    // Reset in mid-run brings back the defaults
    sysRst = 1'b1;
    cyc(2);
    chk({outEn, stFault, stWarn, alertOeN}, 7'h01);
    sysRst = 1'b0;
    rdChk(8'h50, 1'b1, 16'h00BF);
    rdChk(8'h51, 1'b1, 16'hEB70);
    waitOe(0, 1'b1, 4, n);
    chk(outEn, 2'b11);
    wrap_up;
  end
endmodule // otfr_top_tb
